/* File: hdl/mbe_pkg.sv */
// Package with register map, field layout and reset values of the monitor
package mbe_pkg;
    localparam int unsigned ADDR_W           = 6;
    localparam logic [5:0]  OFS_FAULT_STATUS = 6'h00;
    localparam logic [5:0]  OFS_FAULT_ADDR   = 6'h04;
    localparam logic [5:0]  OFS_FAULT_LIMITS = 6'h08;
    localparam logic [5:0]  OFS_RESERVED     = 6'h0C;
    localparam logic [5:0]  OFS_SCRUB_STATE  = 6'h10;
    localparam logic [5:0]  OFS_SCRUB_SETUP  = 6'h14;
    localparam logic [5:0]  OFS_RANGE_LOW    = 6'h18;
    localparam logic [5:0]  OFS_RANGE_HIGH   = 6'h1C;
    localparam logic [5:0]  OFS_CURSOR       = 6'h20;
    localparam logic [5:0]  OFS_SCRUB_LIMITS = 6'h24;
    localparam logic [5:0]  OFS_PATTERN      = 6'h28;
    localparam logic [5:0]  OFS_ALT_LOW      = 6'h2C;
    localparam logic [5:0]  OFS_ALT_HIGH     = 6'h30;
    // Field positions
    localparam int unsigned FIX_TALLY_LSB    = 22;
    localparam int unsigned FIX_TALLY_W      = 10;
    localparam int unsigned FATAL_TALLY_LSB  = 14;
    localparam int unsigned FATAL_TALLY_W    = 8;
    localparam int unsigned DONE_BIT         = 13;
    localparam int unsigned RUN_LIMIT_BIT    = 11;
    localparam int unsigned BLOCK_LIMIT_BIT  = 10;
    localparam int unsigned FIXABLE_BIT      = 9;
    localparam int unsigned FRESH_BIT        = 8;
    localparam int unsigned WRITE_BIT        = 7;
    localparam int unsigned MASTER_LSB       = 3;
    localparam int unsigned SIZE_LSB         = 0;
    localparam int unsigned FIX_EN_BIT       = 1;
    localparam int unsigned FATAL_EN_BIT     = 0;
    // Reset values and bus error response code
    localparam logic [9:0]  FIX_TALLY_RST    = 10'h000;
    localparam logic [7:0]  FATAL_TALLY_RST  = 8'h00;
    localparam logic [31:0] LIMITS_RST       = 32'h0000_0000;
    localparam logic [31:0] SCRUB_REG_RST    = 32'h0000_0000;
    localparam logic [1:0]  RESP_ERROR       = 2'h1;
endpackage

/* File: hdl/mbe_tally.sv */
// Saturating error counter with threshold crossing detection
module mbe_tally
    import mbe_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         step_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] load_val_in,
    input  wire logic [W-1:0] limit_in,
    output logic      [W-1:0] count_out,
    output logic              cross_out
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         at_max;

    // Count holds at all ones rather than wrapping back to zero
    assign at_max    = &count_q;
    assign count_d   = load_in ? load_val_in :
                       (step_in && !at_max) ? count_q + W'(1) : count_q;
    // Crossing only on the step from limit to limit plus one
    assign cross_out = step_in && !load_in && !at_max
                       && (count_q == limit_in);
    assign count_out = count_q;

    // Counter register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

/* File: hdl/mbe_regs.sv */
// Memory bus error monitor: error logging and register bank
// What this block does
// - Registers decoded at offsets 0x00 to 0x30, 0x0C reserved.
// - Correctable error tally sits in status bits 31:22, read/write.
// - Uncorrectable error tally sits in status bits 21:14, read/write.
// - Status bit 13 is a read-only copy of scrub done flag.
// - Run or block limit flag set together with fresh error flag.
// - Fixable flag set for controller errors, cleared for bus errors.
// - Failing address holds full address, read-only, no reset.
// - Limits bits 31:22 hold correctable threshold, reset zero.
// - Limits bits 21:14 hold uncorrectable threshold, reset zero.
// - Step from threshold to threshold+1 freezes info, raises interrupt.
// - Limits bit 1 enables correctable, bit 0 uncorrectable handling.
// - Disabled error type neither interrupts nor holds information.
// - Uncorrectable enable in bit 0 resets to zero.
// - Address, direction, master and size of every transfer are recorded.
// - Threshold crossing freezes status and address, sets fresh flag.
// - Separate counters and thresholds for both error types.
module mbe_regs
    import mbe_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Monitored memory bus
    input  wire logic [31:0] bus_addr_in,
    input  wire logic        bus_write_in,
    input  wire logic [3:0]  bus_master_in,
    input  wire logic [2:0]  bus_size_in,
    input  wire logic        bus_addr_phase_in,
    input  wire logic        bus_ready_in,
    input  wire logic [1:0]  bus_resp_in,
    input  wire logic        fixable_fault_in,
    // Scrub engine status copies
    input  wire logic        scrub_done_in,
    input  wire logic        run_limit_hit_in,
    input  wire logic        block_limit_hit_in,
    // Register port
    input  wire logic        reg_sel_in,
    input  wire logic        reg_write_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic             error_irq_out,
    // Scrub engine register values
    output logic      [31:0] scrub_setup_out,
    output logic      [31:0] range_low_out,
    output logic      [31:0] range_high_out,
    output logic      [31:0] scrub_limits_out,
    output logic      [31:0] init_pattern_out,
    output logic      [31:0] alt_low_out,
    output logic      [31:0] alt_high_out
);
    // Recorded transaction of the current address phase
    logic [31:0] cur_addr_q;
    logic        cur_write_q;
    logic [3:0]  cur_master_q;
    logic [2:0]  cur_size_q;
    // Frozen error information
    logic [31:0] fault_addr_q;
    logic        hold_write_q;
    logic [3:0]  hold_master_q;
    logic [2:0]  hold_size_q;
    logic        run_flag_q;
    logic        block_flag_q;
    logic        fixable_q;
    logic        fresh_q;
    logic [31:0] limits_q;
    logic [31:0] setup_q;
    logic [31:0] rlow_q;
    logic [31:0] rhigh_q;
    logic [31:0] slimits_q;
    logic [31:0] pattern_q;
    logic [31:0] alow_q;
    logic [31:0] ahigh_q;
    logic [31:0] rdata_q;
    logic        irq_q;

    // Address decode
    logic wr;
    logic wr_status;
    logic wr_limits;
    logic wr_setup;
    logic wr_rlow;
    logic wr_rhigh;
    logic wr_slim;
    logic wr_pat;
    logic wr_alow;
    logic wr_ahigh;
    logic hit_status;
    logic hit_addr;
    logic hit_limits;
    logic hit_state;
    logic hit_setup;
    logic hit_rlow;
    logic hit_rhigh;
    logic hit_cursor;
    logic hit_slim;
    logic hit_pat;
    logic hit_alow;
    logic hit_ahigh;
    assign wr         = reg_sel_in && reg_write_in;
    assign hit_status = (reg_addr_in == OFS_FAULT_STATUS);
    assign hit_addr   = (reg_addr_in == OFS_FAULT_ADDR);
    assign hit_limits = (reg_addr_in == OFS_FAULT_LIMITS);
    assign hit_state  = (reg_addr_in == OFS_SCRUB_STATE);
    assign hit_setup  = (reg_addr_in == OFS_SCRUB_SETUP);
    assign hit_rlow   = (reg_addr_in == OFS_RANGE_LOW);
    assign hit_rhigh  = (reg_addr_in == OFS_RANGE_HIGH);
    assign hit_cursor = (reg_addr_in == OFS_CURSOR);
    assign hit_slim   = (reg_addr_in == OFS_SCRUB_LIMITS);
    assign hit_pat    = (reg_addr_in == OFS_PATTERN);
    assign hit_alow   = (reg_addr_in == OFS_ALT_LOW);
    assign hit_ahigh  = (reg_addr_in == OFS_ALT_HIGH);
    assign wr_status  = wr && hit_status;
    assign wr_limits  = wr && hit_limits;
    assign wr_setup   = wr && hit_setup;
    assign wr_rlow    = wr && hit_rlow;
    assign wr_rhigh   = wr && hit_rhigh;
    assign wr_slim    = wr && hit_slim;
    assign wr_pat     = wr && hit_pat;
    assign wr_alow    = wr && hit_alow;
    assign wr_ahigh   = wr && hit_ahigh;

    // Error events seen at the end of a transfer
    logic bus_err;
    logic fix_err;
    assign bus_err = bus_ready_in && (bus_resp_in == RESP_ERROR);
    assign fix_err = fixable_fault_in;

    // Threshold fields and enables
    logic [FIX_TALLY_W-1:0]   fix_limit;
    logic [FATAL_TALLY_W-1:0] fatal_limit;
    logic                     fix_en;
    logic                     fatal_en;
    assign fix_limit   = limits_q[FIX_TALLY_LSB +: FIX_TALLY_W];
    assign fatal_limit = limits_q[FATAL_TALLY_LSB +: FATAL_TALLY_W];
    assign fix_en      = limits_q[FIX_EN_BIT];
    assign fatal_en    = limits_q[FATAL_EN_BIT];

    // Two independent tallies
    logic [FIX_TALLY_W-1:0]   fix_count;
    logic [FATAL_TALLY_W-1:0] fatal_count;
    logic                     fix_cross;
    logic                     fatal_cross;

    mbe_tally #(
        .W (FIX_TALLY_W)
    ) u_fix_tally (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .step_in     (fix_err),
        .load_in     (wr_status),
        .load_val_in (reg_wdata_in[FIX_TALLY_LSB +: FIX_TALLY_W]),
        .limit_in    (fix_limit),
        .count_out   (fix_count),
        .cross_out   (fix_cross)
    );

    mbe_tally #(
        .W (FATAL_TALLY_W)
    ) u_fatal_tally (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .step_in     (bus_err),
        .load_in     (wr_status),
        .load_val_in (reg_wdata_in[FATAL_TALLY_LSB +: FATAL_TALLY_W]),
        .limit_in    (fatal_limit),
        .count_out   (fatal_count),
        .cross_out   (fatal_cross)
    );

    // Capture decision: enabled crossing or scrub limit hit while no error is held
    logic fix_trig;
    logic fatal_trig;
    logic scrub_trig;
    logic capture;
    logic fresh_clr;
    assign fix_trig   = fix_cross && fix_en;
    assign fatal_trig = fatal_cross && fatal_en;
    assign scrub_trig = run_limit_hit_in || block_limit_hit_in;
    assign capture    = !fresh_q && (fix_trig || fatal_trig || scrub_trig);
    assign fresh_clr  = wr_status && !reg_wdata_in[FRESH_BIT];

    // Assembled status word
    logic [31:0] status_word;
    assign status_word = {fix_count, fatal_count,
                          scrub_done_in, 1'b0,
                          run_flag_q, block_flag_q, fixable_q, fresh_q,
                          hold_write_q, hold_master_q, hold_size_q};

    // Read data selection
    logic [31:0] rdata_d;
    assign rdata_d = hit_status ? status_word :
                     hit_addr   ? fault_addr_q :
                     hit_limits ? limits_q :
                     hit_state  ? {18'h00000, scrub_done_in, 13'h0000} :
                     hit_setup  ? setup_q :
                     hit_rlow   ? rlow_q :
                     hit_rhigh  ? rhigh_q :
                     hit_cursor ? 32'h0000_0000 :
                     hit_slim   ? slimits_q :
                     hit_pat    ? pattern_q :
                     hit_alow   ? alow_q :
                     hit_ahigh  ? ahigh_q : 32'h0000_0000;

    // Record every address phase of the monitored bus
    always_ff @(posedge clk_in) begin
        if (bus_addr_phase_in && bus_ready_in) begin
            cur_addr_q   <= bus_addr_in;
            cur_write_q  <= bus_write_in;
            cur_master_q <= bus_master_in;
            cur_size_q   <= bus_size_in;
        end
    end

    // Failing transfer snapshot, not reset
    always_ff @(posedge clk_in) begin
        if (capture) begin
            fault_addr_q  <= cur_addr_q;
            hold_write_q  <= cur_write_q;
            hold_master_q <= cur_master_q;
            hold_size_q   <= cur_size_q;
        end
    end

    // Status flags; a capture wins over a clearing write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fresh_q      <= 1'b0;
            fixable_q    <= 1'b0;
            run_flag_q   <= 1'b0;
            block_flag_q <= 1'b0;
        end else if (capture) begin
            fresh_q      <= 1'b1;
            fixable_q    <= fix_trig && !fatal_trig;
            run_flag_q   <= run_limit_hit_in;
            block_flag_q <= block_limit_hit_in;
        end else if (wr_status) begin
            fresh_q      <= fresh_q && !fresh_clr;
            fixable_q    <= reg_wdata_in[FIXABLE_BIT];
            run_flag_q   <= reg_wdata_in[RUN_LIMIT_BIT];
            block_flag_q <= reg_wdata_in[BLOCK_LIMIT_BIT];
        end
    end

    // Threshold register, reserved bits kept at zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            limits_q <= LIMITS_RST;
        end else if (wr_limits) begin
            limits_q <= {reg_wdata_in[31:14], 12'h000, reg_wdata_in[1:0]};
        end
    end

    // Scrub configuration word, stored for the engine outside
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            setup_q <= SCRUB_REG_RST;
        end else if (wr_setup) begin
            setup_q <= reg_wdata_in;
        end
    end

    // Scrub range low bound
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rlow_q <= SCRUB_REG_RST;
        end else if (wr_rlow) begin
            rlow_q <= reg_wdata_in;
        end
    end

    // Scrub range high bound
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rhigh_q <= SCRUB_REG_RST;
        end else if (wr_rhigh) begin
            rhigh_q <= reg_wdata_in;
        end
    end

    // Scrub run and block thresholds
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            slimits_q <= SCRUB_REG_RST;
        end else if (wr_slim) begin
            slimits_q <= reg_wdata_in;
        end
    end

    // Initialization pattern word
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pattern_q <= SCRUB_REG_RST;
        end else if (wr_pat) begin
            pattern_q <= reg_wdata_in;
        end
    end

    // Second range low bound
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alow_q <= SCRUB_REG_RST;
        end else if (wr_alow) begin
            alow_q <= reg_wdata_in;
        end
    end

    // Second range high bound
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ahigh_q <= SCRUB_REG_RST;
        end else if (wr_ahigh) begin
            ahigh_q <= reg_wdata_in;
        end
    end

    // Read data registered every cycle, one cycle after the address
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // One-cycle interrupt pulse on each capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= capture;
        end
    end

    assign reg_rdata_out    = rdata_q;
    assign error_irq_out    = irq_q;
    assign scrub_setup_out  = setup_q;
    assign range_low_out    = rlow_q;
    assign range_high_out   = rhigh_q;
    assign scrub_limits_out = slimits_q;
    assign init_pattern_out = pattern_q;
    assign alt_low_out      = alow_q;
    assign alt_high_out     = ahigh_q;
endmodule

/* File: tb/mbe_regs_properties.sv */
// Concurrent checks on the error monitor ports
module mbe_regs_properties
    import mbe_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        bus_ready_in,
    input wire logic [1:0]  bus_resp_in,
    input wire logic        fixable_fault_in,
    input wire logic        scrub_done_in,
    input wire logic        run_limit_hit_in,
    input wire logic        block_limit_hit_in,
    input wire logic        reg_sel_in,
    input wire logic        reg_write_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        error_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [31:0] lim_q;
    logic [1:0]  en_q;
    logic        fix_q;
    logic        bus_q;
    logic        scr_q;
    // Expected limits contents and last cycle's error causes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lim_q <= 32'h0000_0000;
        end else if (reg_sel_in && reg_write_in && reg_addr_in == 6'h08) begin
            lim_q <= {reg_wdata_in[31:14], 12'h000, reg_wdata_in[1:0]};
        end
        en_q <= lim_q[1:0];
        fix_q <= fixable_fault_in;
        bus_q <= bus_ready_in && bus_resp_in == RESP_ERROR;
        scr_q <= run_limit_hit_in || block_limit_hit_in;
    end
    property p_irq_pulse;
        error_irq_out |=> !error_irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");
    property p_irq_cause;
        error_irq_out |-> (fix_q && en_q[1]) || (bus_q && en_q[0]) || scr_q;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled cause");
    property p_fresh_set;
        error_irq_out && reg_addr_in == OFS_FAULT_STATUS
            |=> reg_rdata_out[FRESH_BIT];
    endproperty
    a_fresh_set: assert property (p_fresh_set)
        else $error("fresh flag not set on capture");
    property p_fix_flag;
        error_irq_out && reg_addr_in == OFS_FAULT_STATUS && !scr_q
            && !(fix_q && bus_q) |=> reg_rdata_out[FIXABLE_BIT] == $past(fix_q);
    endproperty
    a_fix_flag: assert property (p_fix_flag)
        else $error("fixable flag wrong on capture");
    property p_rsvd_zero;
        reg_addr_in == OFS_RESERVED || reg_addr_in == OFS_CURSOR
            || reg_addr_in > OFS_ALT_HIGH |=> reg_rdata_out == 32'h0000_0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved offset reads nonzero");
    property p_limits_read;
        reg_addr_in == OFS_FAULT_LIMITS |=> reg_rdata_out == $past(lim_q);
    endproperty
    a_limits_read: assert property (p_limits_read)
        else $error("limits register content wrong");
    property p_done_copy;
        reg_addr_in == OFS_FAULT_STATUS && $stable(scrub_done_in)
            |=> reg_rdata_out[DONE_BIT] == $past(scrub_done_in);
    endproperty
    a_done_copy: assert property (p_done_copy)
        else $error("done copy differs from scrub done");
    property p_addr_hold;
        reg_addr_in == OFS_FAULT_ADDR && $past(reg_addr_in) == OFS_FAULT_ADDR
            && !$past(rst_in) && !error_irq_out |=> $stable(reg_rdata_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("failing address changed without capture");
endmodule

/* File: tb/mbe_bus_model.sv */
// Far side model: bus master traffic and controller error line
module mbe_bus_model (
    input  wire logic        clk_in,
    output logic      [31:0] bus_addr_out,
    output logic             bus_write_out,
    output logic      [3:0]  bus_master_out,
    output logic      [2:0]  bus_size_out,
    output logic             bus_addr_phase_out,
    output logic             bus_ready_out,
    output logic      [1:0]  bus_resp_out,
    output logic             fixable_fault_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] ctl = 5'h00;
    logic [7:0] att = 8'h00;
    // Control lines and transfer attributes
    assign {bus_addr_phase_out, bus_ready_out, bus_resp_out} = ctl[4:1];
    assign fixable_fault_out = ctl[0];
    assign {bus_write_out, bus_master_out, bus_size_out} = att;
    initial bus_addr_out = 32'h0000_0000;
    // Address phase, error cycle of the given kind, then lines released
    task automatic fault(input logic [1:0] kind, input logic [31:0] a,
                         input logic [7:0] at);
        @(posedge clk_in) #1;
        ctl = 5'h18;
        att = at;
        bus_addr_out = a;
        @(posedge clk_in) #1;
        ctl = {2'b01, kind == 2'h1 ? 2'h1 : 2'h0, kind == 2'h2};
        @(posedge clk_in) #1;
        ctl = 5'h00;
        att = ~at;
        bus_addr_out = ~a;
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the error monitor register bank
module tb;
    import mbe_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in;
    logic        rst_in = 1'b1;
    logic [31:0] bus_addr_in;
    logic        bus_write_in;
    logic [3:0]  bus_master_in;
    logic [2:0]  bus_size_in;
    logic        bus_addr_phase_in;
    logic        bus_ready_in;
    logic [1:0]  bus_resp_in;
    logic        fixable_fault_in;
    logic        scrub_done_in = 1'b0;
    logic        run_limit_hit_in = 1'b0;
    logic        block_limit_hit_in = 1'b0;
    logic        reg_sel_in = 1'b0;
    logic        reg_write_in = 1'b0;
    logic [5:0]  reg_addr_in = 6'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out;
    logic        error_irq_out;
    logic [31:0] fa;
    logic [31:0] v;
    logic [7:0]  fat;
    wire  [6:0][31:0] scr_o;
    logic [5:0]  scr_ofs [7] = '{OFS_SCRUB_SETUP, OFS_RANGE_LOW,
        OFS_RANGE_HIGH, OFS_SCRUB_LIMITS, OFS_PATTERN, OFS_ALT_LOW,
        OFS_ALT_HIGH};
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          num_errors = 0;
    int          comparisons = 0;
    int          seed = 32;
    int          cyc = 0;
    mbe_regs uut (.clk_in, .rst_in, .bus_addr_in, .bus_write_in,
        .bus_master_in, .bus_size_in, .bus_addr_phase_in, .bus_ready_in,
        .bus_resp_in, .fixable_fault_in, .scrub_done_in,
        .run_limit_hit_in, .block_limit_hit_in, .reg_sel_in,
        .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .error_irq_out, .scrub_setup_out(scr_o[0]),
        .range_low_out(scr_o[1]), .range_high_out(scr_o[2]),
        .scrub_limits_out(scr_o[3]), .init_pattern_out(scr_o[4]),
        .alt_low_out(scr_o[5]), .alt_high_out(scr_o[6]));
    mbe_bus_model m (.clk_in, .bus_addr_out(bus_addr_in),
        .bus_write_out(bus_write_in), .bus_master_out(bus_master_in),
        .bus_size_out(bus_size_in), .bus_addr_phase_out(bus_addr_phase_in),
        .bus_ready_out(bus_ready_in), .bus_resp_out(bus_resp_in),
        .fixable_fault_out(fixable_fault_in));
    // Clock generation
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Full word register write, one cycle strobe
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_in) #1;
        {reg_sel_in, reg_write_in, reg_addr_in, reg_wdata_in} = {2'b11, a, d};
        @(posedge clk_in) #1;
        {reg_sel_in, reg_write_in} = 2'b00;
    endtask
    // Register read; the expectation is queued for the monitor
    task automatic rreg(input logic [5:0] a, input logic [31:0] e, m);
        @(posedge clk_in) #1;
        {reg_sel_in, reg_write_in, reg_addr_in} = {2'b10, a};
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk_in) #1;
        reg_sel_in = 1'b0;
    endtask
    // One error event with random address and attributes
    task automatic err(input logic [1:0] k, input logic ex_irq);
        fa = $random(seed);
        fat = 8'($random(seed));
        m.fault(k, fa, fat);
        check("irq", {31'h0, error_irq_out}, {31'h0, ex_irq});
    endtask
    // One-cycle scrub limit pulse, run or block kind
    task automatic scrub_hit(input logic r);
        @(posedge clk_in) #1;
        {run_limit_hit_in, block_limit_hit_in} = {r, !r};
        @(posedge clk_in) #1;
        {run_limit_hit_in, block_limit_hit_in} = 2'b00;
        check("irq", {31'h0, error_irq_out}, 32'h0000_0001);
    endtask
    // Read data monitor against the oldest queued note
    always @(posedge clk_in) begin
        if (reg_sel_in && !reg_write_in) begin
            #2;
            check("rdata", reg_rdata_out & msk_q.pop_front(),
                  exp_q.pop_front());
        end
    end
    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        #1 rst_in = 1'b0;
        rreg(OFS_FAULT_LIMITS, 32'h0, '1);
        rreg(OFS_FAULT_STATUS, 32'h0, 32'hFFFF_FF00);
        rreg(OFS_RESERVED, 32'h0, '1);
        for (int i = 0; i < 3; i++) begin
            v = $random(seed);
            wreg(OFS_FAULT_LIMITS, v);
            rreg(OFS_FAULT_LIMITS, {v[31:14], 12'h0, v[1:0]}, '1);
        end
        for (int i = 0; i < 7; i++) begin
            v = $random(seed);
            wreg(scr_ofs[i], v);
            rreg(scr_ofs[i], v, '1);
            check("scrub copy", scr_o[i], v);
        end
        v = $random(seed);
        wreg(OFS_PATTERN, v);
        wreg(OFS_CURSOR, v);
        rreg(OFS_PATTERN, v, '1);
        rreg(OFS_CURSOR, 32'h0, '1);
        wreg(OFS_FAULT_LIMITS, 32'h0000_4001);
        err(2'h1, 1'b0);
        err(2'h1, 1'b1);
        rreg(OFS_FAULT_STATUS, {18'h00002, 6'h01, fat}, '1);
        rreg(OFS_FAULT_ADDR, fa, '1);
        v = fa;
        wreg(OFS_FAULT_ADDR, ~v);
        wreg(OFS_FAULT_LIMITS, 32'h0000_4003);
        err(2'h2, 1'b0);
        rreg(OFS_FAULT_ADDR, v, '1);
        rreg(OFS_FAULT_STATUS, 32'h0040_8100, 32'hFFFF_FF00);
        wreg(OFS_FAULT_STATUS, 32'h0);
        err(2'h2, 1'b1);
        rreg(OFS_FAULT_STATUS, {18'h00100, 6'h03, fat}, '1);
        wreg(OFS_FAULT_STATUS, 32'h0);
        wreg(OFS_FAULT_LIMITS, 32'h0);
        err(2'h1, 1'b0);
        err(2'h2, 1'b0);
        rreg(OFS_FAULT_STATUS, 32'h0040_4000, 32'hFFFF_FF00);
        scrub_done_in = 1'b1;
        wreg(OFS_FAULT_STATUS, 32'h0);
        rreg(OFS_FAULT_STATUS, 32'h0000_2000, 32'hFFFF_FF00);
        rreg(OFS_SCRUB_STATE, 32'h0000_2000, 32'h0000_2000);
        scrub_hit(1'b1);
        rreg(OFS_FAULT_STATUS, 32'h0000_2900, 32'hFFFF_FF00);
        wreg(OFS_FAULT_STATUS, 32'h0);
        scrub_hit(1'b0);
        rreg(OFS_FAULT_STATUS, 32'h0000_2500, 32'hFFFF_FF00);
        repeat (3) @(posedge clk_in);
        complete_run();
    end
endmodule
bind mbe_regs mbe_regs_properties chk (.clk_in, .rst_in, .bus_ready_in,
    .bus_resp_in, .fixable_fault_in, .scrub_done_in, .run_limit_hit_in,
    .block_limit_hit_in, .reg_sel_in, .reg_write_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .error_irq_out);
